//--- logic/pief_pkg.sv
// ****************************************************************
// register map, field positions and carriers
// ****************************************************************
package pief_pkg;

  // byte offsets of the word-aligned registers
  localparam logic [4:0] OFS_ENABLE_SIX   = 5'h00;
  localparam logic [4:0] OFS_ENABLE_SEVEN = 5'h04;
  localparam logic [4:0] OFS_ENABLE_EIGHT = 5'h08;
  localparam logic [4:0] OFS_STATUS_ZERO  = 5'h0c;
  localparam logic [4:0] OFS_REQUEST_ONE  = 5'h10;
  localparam logic [4:0] OFS_REQUEST_TWO  = 5'h14;
  localparam logic [4:0] OFS_CORE_CTRL    = 5'h18;

  // implemented bits of each register, for status zero the writable ones; all others read zero except the status zero summary bit
  localparam logic [7:0] MASK_ENABLE_SIX   = 8'h83;
  localparam logic [7:0] MASK_ENABLE_SEVEN = 8'h21;
  localparam logic [7:0] MASK_ENABLE_EIGHT = 8'hc7;
  localparam logic [7:0] MASK_STATUS_WR    = 8'h21;
  localparam logic [7:0] MASK_REQUEST_ONE  = 8'hc3;
  localparam logic [7:0] MASK_REQUEST_TWO  = 8'h43;
  localparam logic [7:0] MASK_CORE_CTRL    = 8'h40;

  // enable six
  localparam int BIT_CLOCK_RECOVERY = 7;
  localparam int BIT_CAPCMP_TWO     = 1;
  localparam int BIT_CAPCMP_ONE     = 0;
  // enable seven
  localparam int BIT_NONVOLATILE    = 5;
  localparam int BIT_WAVEFORM_GEN   = 0;
  // enable eight
  localparam int BIT_DISPLAY        = 7;
  localparam int BIT_CALENDAR       = 6;
  localparam int BIT_MEAS_PULSE     = 2;
  localparam int BIT_MEAS_PERIOD    = 1;
  localparam int BIT_MEAS_OVERFLOW  = 0;
  // status zero
  localparam int BIT_TIMER_ZERO     = 5;
  localparam int BIT_PIN_SUMMARY    = 4;
  localparam int BIT_EXTERNAL_PIN   = 0;
  // request one
  localparam int BIT_OSC_FAILSAFE   = 7;
  localparam int BIT_CLOCK_SWITCH   = 6;
  localparam int BIT_CONV_THRESHOLD = 1;
  localparam int BIT_CONV_DONE      = 0;
  // request two
  localparam int BIT_ZERO_CROSS     = 6;
  localparam int BIT_COMPARATOR_TWO = 1;
  localparam int BIT_COMPARATOR_ONE = 0;
  // core control
  localparam int BIT_GLOBAL_GATE    = 6;

  // values after any reset
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic        RESET_WAIT = 1'b1;

  // one-cycle event pulses that set the local flags
  typedef struct packed {
    logic timer_zero_overflow;
    logic external_pin;
    logic osc_failsafe;
    logic clock_switch;
    logic converter_threshold;
    logic converter_done;
    logic zero_cross;
    logic comparator_two;
    logic comparator_one;
  } pief_event_s;

  // request levels of peripherals gated by enables six to eight
  typedef struct packed {
    logic clock_recovery;
    logic capcmp_two;
    logic capcmp_one;
    logic nonvolatile_done;
    logic waveform_gen;
    logic display;
    logic calendar;
    logic meas_pulse_width;
    logic meas_period;
    logic meas_overflow;
  } pief_periph_s;

  // whole state of the block
  typedef struct packed {
    logic [7:0]  enable_six;
    logic [7:0]  enable_seven;
    logic [7:0]  enable_eight;
    logic [7:0]  status_zero;
    logic [7:0]  request_one;
    logic [7:0]  request_two;
    logic [7:0]  core_ctrl;
    logic        wait_req;
    logic [31:0] rdata;
    logic        irq;
  } pief_state_s;

endpackage

//--- logic/pief_irq_flags.sv
`timescale 1ns/1ns
module pief_irq_flags #(
  parameter int EDGE_FLAG_W = 40
) (
  input  wire logic                     CLK_I,
  input  wire logic                     RST_B_I,
  input  wire logic [4:0]               AVS_ADDRESS_I,
  input  wire logic                     AVS_READ_I,
  input  wire logic                     AVS_WRITE_I,
  input  wire logic [31:0]              AVS_WRITEDATA_I,
  input  wire logic [3:0]               AVS_BYTEENABLE_I,
  output logic      [31:0]              AVS_READDATA_O,
  output logic                          AVS_WAITREQUEST_O,
  input  wire pief_pkg::pief_event_s    HW_EVENT_I,
  input  wire pief_pkg::pief_event_s    FLAG_ENABLE_I,
  input  wire pief_pkg::pief_periph_s   PERIPH_REQ_I,
  input  wire logic [EDGE_FLAG_W-1:0]   PORT_EDGE_FLAGS_I,
  output logic                          CORE_IRQ_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  pief_pkg::pief_state_s s_reg;
  pief_pkg::pief_state_s s_next;
  logic [4:0]            word_addr;
  logic                  bus_req;
  logic                  wr_commit;
  logic                  any_local;
  logic                  any_periph;
  logic                  edge_any;

  // low address bits ignored: every register is one aligned word
  assign word_addr = {AVS_ADDRESS_I[4:2], 2'b00};
  assign bus_req   = AVS_READ_I | AVS_WRITE_I;
  // write lands only on the edge where waitrequest is seen low
  assign wr_commit = AVS_WRITE_I & ~s_reg.wait_req & AVS_BYTEENABLE_I[0];
  // summary source as one net so the check can look one edge back
  assign edge_any  = |PORT_EDGE_FLAGS_I;

  // ****************************************************************
  // request gathering
  // ****************************************************************
  // peripheral requests of enables six to eight
  always_comb begin
    any_periph = 1'b0;
    any_periph = any_periph
      | (s_reg.enable_six[pief_pkg::BIT_CLOCK_RECOVERY] & PERIPH_REQ_I.clock_recovery);
    any_periph = any_periph
      | (s_reg.enable_six[pief_pkg::BIT_CAPCMP_TWO] & PERIPH_REQ_I.capcmp_two)
      | (s_reg.enable_six[pief_pkg::BIT_CAPCMP_ONE] & PERIPH_REQ_I.capcmp_one);
    any_periph = any_periph
      | (s_reg.enable_seven[pief_pkg::BIT_NONVOLATILE] & PERIPH_REQ_I.nonvolatile_done);
    any_periph = any_periph
      | (s_reg.enable_seven[pief_pkg::BIT_WAVEFORM_GEN] & PERIPH_REQ_I.waveform_gen);
    any_periph = any_periph
      | (s_reg.enable_eight[pief_pkg::BIT_DISPLAY] & PERIPH_REQ_I.display)
      | (s_reg.enable_eight[pief_pkg::BIT_CALENDAR] & PERIPH_REQ_I.calendar);
    any_periph = any_periph
      | (s_reg.enable_eight[pief_pkg::BIT_MEAS_PULSE] & PERIPH_REQ_I.meas_pulse_width)
      | (s_reg.enable_eight[pief_pkg::BIT_MEAS_PERIOD] & PERIPH_REQ_I.meas_period)
      | (s_reg.enable_eight[pief_pkg::BIT_MEAS_OVERFLOW] & PERIPH_REQ_I.meas_overflow);
  end

  // local flags against their enables held outside this slice
  always_comb begin
    any_local = 1'b0;
    any_local = any_local
      | (s_reg.status_zero[pief_pkg::BIT_TIMER_ZERO] & FLAG_ENABLE_I.timer_zero_overflow)
      | (s_reg.status_zero[pief_pkg::BIT_EXTERNAL_PIN] & FLAG_ENABLE_I.external_pin)
      | (s_reg.request_one[pief_pkg::BIT_OSC_FAILSAFE] & FLAG_ENABLE_I.osc_failsafe)
      | (s_reg.request_one[pief_pkg::BIT_CLOCK_SWITCH] & FLAG_ENABLE_I.clock_switch)
      | (s_reg.request_one[pief_pkg::BIT_CONV_THRESHOLD] & FLAG_ENABLE_I.converter_threshold)
      | (s_reg.request_one[pief_pkg::BIT_CONV_DONE] & FLAG_ENABLE_I.converter_done)
      | (s_reg.request_two[pief_pkg::BIT_ZERO_CROSS] & FLAG_ENABLE_I.zero_cross)
      | (s_reg.request_two[pief_pkg::BIT_COMPARATOR_TWO] & FLAG_ENABLE_I.comparator_two)
      | (s_reg.request_two[pief_pkg::BIT_COMPARATOR_ONE] & FLAG_ENABLE_I.comparator_one);
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [7:0] rd_byte;
    rd_byte = 8'h00;
    s_next  = s_reg;

    // read mux; unmapped offsets answer zero
    case (word_addr)
      pief_pkg::OFS_ENABLE_SIX:   rd_byte = s_reg.enable_six;
      pief_pkg::OFS_ENABLE_SEVEN: rd_byte = s_reg.enable_seven;
      pief_pkg::OFS_ENABLE_EIGHT: rd_byte = s_reg.enable_eight;
      pief_pkg::OFS_STATUS_ZERO:  rd_byte = s_reg.status_zero;
      pief_pkg::OFS_REQUEST_ONE:  rd_byte = s_reg.request_one;
      pief_pkg::OFS_REQUEST_TWO:  rd_byte = s_reg.request_two;
      pief_pkg::OFS_CORE_CTRL:    rd_byte = s_reg.core_ctrl;
      default:                    rd_byte = 8'h00;
    endcase

    // one wait cycle per access keeps readdata a plain flop
    s_next.wait_req = 1'b1;
    if (bus_req && s_reg.wait_req) begin
      s_next.wait_req = 1'b0;
      s_next.rdata    = AVS_READ_I ? {24'h00_0000, rd_byte} : pief_pkg::RESET_WORD;
    end

    // software writes, masked to implemented bits
    if (wr_commit) begin
      case (word_addr)
        pief_pkg::OFS_ENABLE_SIX:
          s_next.enable_six = AVS_WRITEDATA_I[7:0] & pief_pkg::MASK_ENABLE_SIX;
        pief_pkg::OFS_ENABLE_SEVEN:
          s_next.enable_seven = AVS_WRITEDATA_I[7:0] & pief_pkg::MASK_ENABLE_SEVEN;
        pief_pkg::OFS_ENABLE_EIGHT:
          s_next.enable_eight = AVS_WRITEDATA_I[7:0] & pief_pkg::MASK_ENABLE_EIGHT;
        pief_pkg::OFS_STATUS_ZERO:
          s_next.status_zero = AVS_WRITEDATA_I[7:0] & pief_pkg::MASK_STATUS_WR;
        pief_pkg::OFS_REQUEST_ONE:
          s_next.request_one = AVS_WRITEDATA_I[7:0] & pief_pkg::MASK_REQUEST_ONE;
        pief_pkg::OFS_REQUEST_TWO:
          s_next.request_two = AVS_WRITEDATA_I[7:0] & pief_pkg::MASK_REQUEST_TWO;
        pief_pkg::OFS_CORE_CTRL:
          s_next.core_ctrl = AVS_WRITEDATA_I[7:0] & pief_pkg::MASK_CORE_CTRL;
        default: ;
      endcase
    end

    // hardware sets after the write so a same-cycle event is not lost
    if (HW_EVENT_I.timer_zero_overflow)
      s_next.status_zero[pief_pkg::BIT_TIMER_ZERO] = 1'b1;
    if (HW_EVENT_I.external_pin)
      s_next.status_zero[pief_pkg::BIT_EXTERNAL_PIN] = 1'b1;
    if (HW_EVENT_I.osc_failsafe)
      s_next.request_one[pief_pkg::BIT_OSC_FAILSAFE] = 1'b1;
    if (HW_EVENT_I.clock_switch)
      s_next.request_one[pief_pkg::BIT_CLOCK_SWITCH] = 1'b1;
    if (HW_EVENT_I.converter_threshold)
      s_next.request_one[pief_pkg::BIT_CONV_THRESHOLD] = 1'b1;
    if (HW_EVENT_I.converter_done)
      s_next.request_one[pief_pkg::BIT_CONV_DONE] = 1'b1;
    if (HW_EVENT_I.zero_cross)
      s_next.request_two[pief_pkg::BIT_ZERO_CROSS] = 1'b1;
    if (HW_EVENT_I.comparator_two)
      s_next.request_two[pief_pkg::BIT_COMPARATOR_TWO] = 1'b1;
    if (HW_EVENT_I.comparator_one)
      s_next.request_two[pief_pkg::BIT_COMPARATOR_ONE] = 1'b1;

    // read-only summary; clears only when every edge flag is clear
    s_next.status_zero[pief_pkg::BIT_PIN_SUMMARY] = |PORT_EDGE_FLAGS_I;

    // global gate over every source, one flop late
    s_next.irq = s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE]
               & (any_local | any_periph);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // every reset source arrives here as one reset line
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_reg.enable_six   <= pief_pkg::RESET_BYTE;
      s_reg.enable_seven <= pief_pkg::RESET_BYTE;
      s_reg.enable_eight <= pief_pkg::RESET_BYTE;
      s_reg.status_zero  <= pief_pkg::RESET_BYTE;
      s_reg.request_one  <= pief_pkg::RESET_BYTE;
      s_reg.request_two  <= pief_pkg::RESET_BYTE;
      s_reg.core_ctrl    <= pief_pkg::RESET_BYTE;
      s_reg.wait_req     <= pief_pkg::RESET_WAIT;
      s_reg.rdata        <= pief_pkg::RESET_WORD;
      s_reg.irq          <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign AVS_READDATA_O    = s_reg.rdata;
  assign AVS_WAITREQUEST_O = s_reg.wait_req;
  assign CORE_IRQ_O        = s_reg.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  // a request is answered one cycle after it is taken
  a_bus_one_wait: assert property (bus_req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest did not drop after one cycle");
  a_bus_no_stall: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");

  // reserved enable bits never read back as one
  a_reserved_zero: assert property (
    ((s_reg.enable_six & ~pief_pkg::MASK_ENABLE_SIX) == 8'h00)
    && ((s_reg.enable_seven & ~pief_pkg::MASK_ENABLE_SEVEN) == 8'h00)
    && ((s_reg.status_zero & ~(pief_pkg::MASK_STATUS_WR | 8'h10)) == 8'h00)
    && ((s_reg.request_one & ~pief_pkg::MASK_REQUEST_ONE) == 8'h00)
    && ((s_reg.enable_eight & ~pief_pkg::MASK_ENABLE_EIGHT) == 8'h00)
    && ((s_reg.request_two & ~pief_pkg::MASK_REQUEST_TWO) == 8'h00))
    else $error("unimplemented bit found set");

  a_timer_flag_set: assert property (HW_EVENT_I.timer_zero_overflow |=>
    s_reg.status_zero[pief_pkg::BIT_TIMER_ZERO])
    else $error("timer zero flag not set by event");

  a_pin_summary_or: assert property (
    1'b1 |=> s_reg.status_zero[pief_pkg::BIT_PIN_SUMMARY] == $past(edge_any))
    else $error("pin-change summary differs from edge flags");

  a_osc_flag_sticky: assert property (
    s_reg.request_one[pief_pkg::BIT_OSC_FAILSAFE] && !wr_commit
    |=> s_reg.request_one[pief_pkg::BIT_OSC_FAILSAFE])
    else $error("fail-safe flag dropped without a write");

  a_conv_done_set: assert property (HW_EVENT_I.converter_done |=>
    s_reg.request_one[pief_pkg::BIT_CONV_DONE])
    else $error("converter done flag not set");

  a_comparator_set: assert property (
    HW_EVENT_I.comparator_one |=> s_reg.request_two[pief_pkg::BIT_COMPARATOR_ONE])
    else $error("comparator one flag not set");

  a_comparator_two: assert property (HW_EVENT_I.comparator_two |=>
    s_reg.request_two[pief_pkg::BIT_COMPARATOR_TWO])
    else $error("comparator two flag not set");

  a_set_beats_clear: assert property (
    wr_commit && word_addr == pief_pkg::OFS_REQUEST_TWO && HW_EVENT_I.zero_cross
    |=> s_reg.request_two[pief_pkg::BIT_ZERO_CROSS])
    else $error("zero-cross event lost to a clearing write");

  a_gate_blocks: assert property (
    !s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE] |=> !CORE_IRQ_O)
    else $error("interrupt passed a closed global gate");

  a_recovery_irq: assert property (
    s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE] && PERIPH_REQ_I.clock_recovery
    && s_reg.enable_six[pief_pkg::BIT_CLOCK_RECOVERY] |=> CORE_IRQ_O)
    else $error("enabled clock recovery request not forwarded");

  a_display_blocked: assert property (
    PERIPH_REQ_I == pief_pkg::pief_periph_s'(10'h010) && $past(PERIPH_REQ_I) == PERIPH_REQ_I
    && !s_reg.enable_eight[pief_pkg::BIT_DISPLAY] && (s_reg.status_zero & 8'h21) == 8'h00
    && s_reg.request_one == 8'h00 && s_reg.request_two == 8'h00 |=> !CORE_IRQ_O)
    else $error("disabled display request reached the core");

  // ****************************************************************
  // event and routing checks
  // ****************************************************************
  // each event shows in its flag one edge later
  a_external_set: assert property (HW_EVENT_I.external_pin |=>
    s_reg.status_zero[pief_pkg::BIT_EXTERNAL_PIN])
    else $error("external pin flag not set by event");

  a_switch_set: assert property (HW_EVENT_I.clock_switch |=>
    s_reg.request_one[pief_pkg::BIT_CLOCK_SWITCH])
    else $error("clock switch flag not set by event");

  a_threshold_set: assert property (HW_EVENT_I.converter_threshold |=>
    s_reg.request_one[pief_pkg::BIT_CONV_THRESHOLD])
    else $error("converter threshold flag not set by event");

  a_zero_cross_set: assert property (HW_EVENT_I.zero_cross |=>
    s_reg.request_two[pief_pkg::BIT_ZERO_CROSS])
    else $error("zero-cross flag not set by event");

  // a flag only drops through a software write
  a_zero_cross_sticky: assert property (
    s_reg.request_two[pief_pkg::BIT_ZERO_CROSS] && !wr_commit
    |=> s_reg.request_two[pief_pkg::BIT_ZERO_CROSS])
    else $error("zero-cross flag dropped without a write");

  // enabled outside requests reach the core behind an open gate
  a_capcmp_irq: assert property (
    s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE]
    && ((PERIPH_REQ_I.capcmp_two && s_reg.enable_six[pief_pkg::BIT_CAPCMP_TWO])
    || (PERIPH_REQ_I.capcmp_one && s_reg.enable_six[pief_pkg::BIT_CAPCMP_ONE]))
    |=> CORE_IRQ_O)
    else $error("enabled capture request not forwarded");

  a_memory_irq: assert property (
    s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE] && PERIPH_REQ_I.nonvolatile_done
    && s_reg.enable_seven[pief_pkg::BIT_NONVOLATILE] |=> CORE_IRQ_O)
    else $error("enabled memory request not forwarded");

  a_waveform_irq: assert property (
    s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE] && PERIPH_REQ_I.waveform_gen
    && s_reg.enable_seven[pief_pkg::BIT_WAVEFORM_GEN] |=> CORE_IRQ_O)
    else $error("enabled waveform request not forwarded");

  a_calendar_irq: assert property (
    s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE] && PERIPH_REQ_I.calendar
    && s_reg.enable_eight[pief_pkg::BIT_CALENDAR] |=> CORE_IRQ_O)
    else $error("enabled calendar request not forwarded");

  a_meas_irq: assert property (
    s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE]
    && ((PERIPH_REQ_I.meas_pulse_width && s_reg.enable_eight[pief_pkg::BIT_MEAS_PULSE])
    || (PERIPH_REQ_I.meas_period && s_reg.enable_eight[pief_pkg::BIT_MEAS_PERIOD])
    || (PERIPH_REQ_I.meas_overflow && s_reg.enable_eight[pief_pkg::BIT_MEAS_OVERFLOW]))
    |=> CORE_IRQ_O)
    else $error("enabled measurement request not forwarded");

  // local flag with its outside enable
  a_local_irq: assert property (
    s_reg.core_ctrl[pief_pkg::BIT_GLOBAL_GATE] && FLAG_ENABLE_I.comparator_one
    && s_reg.request_two[pief_pkg::BIT_COMPARATOR_ONE] |=> CORE_IRQ_O)
    else $error("enabled local flag not forwarded");

  // held reset keeps the enable, status and request registers at zero and the core request low; looked at through reset itself
  a_reset_clears: assert property (disable iff (1'b0)
    !RST_B_I ##1 !RST_B_I
    |-> s_reg.enable_six == pief_pkg::RESET_BYTE
    && s_reg.enable_seven == pief_pkg::RESET_BYTE
    && s_reg.enable_eight == pief_pkg::RESET_BYTE
    && s_reg.status_zero == pief_pkg::RESET_BYTE
    && s_reg.request_one == pief_pkg::RESET_BYTE
    && s_reg.request_two == pief_pkg::RESET_BYTE && !CORE_IRQ_O)
    else $error("register not cleared by reset");

  c_read_access:  cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
  c_flag_cleared: cover property (s_reg.request_one[0] ##1 !s_reg.request_one[0]);
  c_irq_raised:   cover property (!CORE_IRQ_O ##1 CORE_IRQ_O);
  c_set_wins:     cover property (wr_commit && HW_EVENT_I.zero_cross);
  c_summary_set:  cover property (!s_reg.status_zero[4] ##1 s_reg.status_zero[4]);

endmodule

//--- testbench/pief_periph_model.sv
`timescale 1ns/1ns
// ****************************************************************
// peripherals, port logic and enables around the flag block
// ****************************************************************
module pief_periph_model (
  input  wire logic             clk_i,
  output pief_pkg::pief_event_s  event_o,
  output pief_pkg::pief_event_s  flag_en_o,
  output pief_pkg::pief_periph_s req_o,
  output logic [3:0]             edges_o
);
  // all quiet from time zero
  initial begin
    event_o = '0;
    flag_en_o = '0;
    req_o = '0;
    edges_o = '0;
  end

  // one-cycle event; a peripheral only ever raises, never lowers a flag
  task automatic fire(input int idx);
    @(posedge clk_i);
    event_o <= pief_pkg::pief_event_s'(9'h001 << idx);
    @(posedge clk_i);
    event_o <= '0;
  endtask

  // level inputs change together, just after an edge
  task automatic levels(input logic [8:0] en, input logic [9:0] req, input logic [3:0] edg);
    @(posedge clk_i);
    flag_en_o <= en;
    req_o <= req;
    edges_o <= edg;
  endtask
endmodule

//--- testbench/pief_irq_flags_bench.sv
`timescale 1ns/1ns
// ****************************************************************
// self-checking bench of the peripheral flag block
// ****************************************************************
module pief_irq_flags_bench;
  logic                   clk;
  logic                   rst_b;
  logic                   rd;
  logic                   wr;
  logic [4:0]             addr;
  logic [31:0]            wdata;
  logic [31:0]            rdata;
  logic [31:0]            q;
  logic [3:0]             be;
  logic [3:0]             edges;
  logic                   waitreq;
  logic                   irq;
  pief_pkg::pief_event_s  ev;
  pief_pkg::pief_event_s  fen;
  pief_pkg::pief_periph_s req;
  int                     n_errors = 0;
  int                     tests_run = 0;
  logic [4:0]             ev_ofs [9];
  logic [7:0]             ev_bit [9];
  logic [4:0]             pr_ofs [10];
  logic [7:0]             pr_bit [10];

  // narrow edge vector keeps the summary case short
  pief_irq_flags #(.EDGE_FLAG_W(4)) dut_u (
    .CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .HW_EVENT_I(ev),
    .FLAG_ENABLE_I(fen), .PERIPH_REQ_I(req), .PORT_EDGE_FLAGS_I(edges), .CORE_IRQ_O(irq));

  pief_periph_model pm_u (.clk_i(clk), .event_o(ev), .flag_en_o(fen), .req_o(req),
    .edges_o(edges));

  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    // only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hf);
    check(q, {24'h0, exp});
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // every offset, the unmapped one included, reads zero after reset
  task automatic reset_values;
    for (int i = 0; i < 8; i++) rd_chk(5'(i * 4), 8'h00);
  endtask

  // enables: only implemented bits stick; lane 0 off means no write
  task automatic enable_bits;
    logic [7:0] m [3];
    m = '{8'h83, 8'h21, 8'hc7};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 5'(i * 4), 8'hff, 4'hf);
      rd_chk(5'(i * 4), m[i]);
      bus(1'b1, 5'(i * 4), 8'h00, 4'he);
      rd_chk(5'(i * 4), m[i]);
      bus(1'b1, 5'(i * 4), 8'h00, 4'hf);
      rd_chk(5'(i * 4), 8'h00);
    end
  endtask

  // each event sets its own flag, which stays until written zero
  task automatic event_flags;
    for (int i = 0; i < 9; i++) begin
      pm_u.fire(i);
      ticks(2);
      rd_chk(ev_ofs[i], ev_bit[i]);
      bus(1'b1, ev_ofs[i], 8'h00, 4'hf);
      rd_chk(ev_ofs[i], 8'h00);
    end
  endtask

  // an event in the commit cycle of a clearing write beats the write
  task automatic set_wins;
    fork
      bus(1'b1, pief_pkg::OFS_REQUEST_TWO, 8'h00, 4'hf);
      begin
        ticks(1);
        pm_u.fire(2);
      end
    join
    rd_chk(pief_pkg::OFS_REQUEST_TWO, 8'h40);
    bus(1'b1, pief_pkg::OFS_REQUEST_TWO, 8'h00, 4'hf);
  endtask

  // software may set flags; the summary bit cannot be written
  task automatic software_access;
    logic [7:0] m [3];
    m = '{8'h21, 8'hc3, 8'h43};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 5'(12 + i * 4), 8'hff, 4'hf);
      rd_chk(5'(12 + i * 4), m[i]);
      bus(1'b1, 5'(12 + i * 4), 8'h00, 4'hf);
    end
  endtask

  // summary follows the edge flags, writes to it have no effect
  task automatic pin_summary;
    pm_u.levels(9'h000, 10'h000, 4'h8);
    rd_chk(pief_pkg::OFS_STATUS_ZERO, 8'h10);
    bus(1'b1, pief_pkg::OFS_STATUS_ZERO, 8'h00, 4'hf);
    rd_chk(pief_pkg::OFS_STATUS_ZERO, 8'h10);
    pm_u.levels(9'h000, 10'h000, 4'h0);
    rd_chk(pief_pkg::OFS_STATUS_ZERO, 8'h00);
  endtask

  // core request needs flag, enable and the global gate
  task automatic irq_routing;
    pm_u.levels(9'h1ff, 10'h000, 4'h0);
    pm_u.fire(0);
    ticks(3);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, pief_pkg::OFS_CORE_CTRL, 8'h40, 4'hf);
    ticks(3);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, pief_pkg::OFS_REQUEST_TWO, 8'h00, 4'hf);
    ticks(3);
    check({31'h0, irq}, 32'h0);
    for (int j = 0; j < 10; j++) begin
      pm_u.levels(9'h000, 10'(1 << j), 4'h0);
      ticks(3);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, pr_ofs[j], pr_bit[j], 4'hf);
      ticks(3);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, pr_ofs[j], 8'h00, 4'hf);
    end
    pm_u.levels(9'h000, 10'h000, 4'h0);
  endtask

  // a second reset in mid-run clears enables and flags again
  task automatic mid_reset;
    bus(1'b1, pief_pkg::OFS_ENABLE_EIGHT, 8'hff, 4'hf);
    pm_u.fire(8);
    ticks(2);
    rst_b <= 1'b0;
    ticks(2);
    rst_b <= 1'b1;
    rd_chk(pief_pkg::OFS_ENABLE_EIGHT, 8'h00);
    rd_chk(pief_pkg::OFS_STATUS_ZERO, 8'h00);
    rd_chk(pief_pkg::OFS_CORE_CTRL, 8'h00);
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    wdata = '0;
    be = 4'hf;
    ev_ofs = '{5'h14, 5'h14, 5'h14, 5'h10, 5'h10, 5'h10, 5'h10, 5'h0c, 5'h0c};
    ev_bit = '{8'h01, 8'h02, 8'h40, 8'h01, 8'h02, 8'h40, 8'h80, 8'h01, 8'h20};
    pr_ofs = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h04, 5'h04, 5'h00, 5'h00, 5'h00};
    pr_bit = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h80, 8'h01, 8'h20, 8'h01, 8'h02, 8'h80};
    ticks(20);
    rst_b <= 1'b1;
    reset_values();
    enable_bits();
    event_flags();
    set_wins();
    software_access();
    pin_summary();
    irq_routing();
    mid_reset();
    end_of_test();
  end

  // watchdog: the whole run needs about four hundred and thirty cycles
  initial begin
    ticks(2000);
    n_errors++;
    end_of_test();
  end
endmodule
